// ### src/rcl_regs.vh
/*
 Register offsets, field positions, reset values and counts of the
 reference clock lock and data rate measurement block.
 Assumes inclusion by its bare name from the design files that use it.
*/
// How it works
// RULE_01: Recovery mode field value 3 in control 0x8 selects reference-assisted lock.
// RULE_02: Reference buffer stays off until software clears its power-down bit.
// RULE_03: Setting the measure enable bit arms the fine rate measurement.
// RULE_04: Software never enables reference lock and measurement together.
// RULE_05: Lock target is reference over band divider times two to ratio minus one.
// RULE_06: Two-bit band field picks the reference range, default lowest band.
// RULE_07: Four-bit ratio code n gives a multiple of two to n minus one.
// RULE_08: After band or ratio changes software pulses the acquire restart bit.
// RULE_09: While tracking, error over 1000 ppm against reference raises lock lost.
// RULE_10: Compare-data bit makes tracking check the oscillator against incoming data.
// RULE_11: Measurement counts data ticks against a fixed reference window.
// RULE_12: Measure enable is a level; repeated restarts need no re-enable.
// RULE_13: Restart pulse on measure restart bit clears done and starts measuring.
// RULE_14: Done flag reads 0 while running and 1 once finished.
// RULE_15: Result is 24 bits over three registers, high byte at offset 0x0.
// RULE_16: Software derives the data rate from count, reference and rate fields.
// RULE_17: Measurement ends 2048 times two to the band code reference periods later.
// RULE_18: Software discards a measurement taken while lock lost is high.
// RULE_19: Software sets band, then enable, then pulses restart.
// RULE_20: During acquisition lock lost drops once within 250 ppm of target.
// RULE_21: All result bytes update together when the done flag rises.
`ifndef RCL_REGS_VH
`define RCL_REGS_VH

`define RCL_ADDR_W 6
`define RCL_ADDR_COUNT_HIGH 6'h00
`define RCL_ADDR_COUNT_MID 6'h01
`define RCL_ADDR_COUNT_LOW 6'h02
`define RCL_ADDR_RATE_READBACK 6'h05
`define RCL_ADDR_STATUS 6'h06
`define RCL_ADDR_CTRL_A 6'h08
`define RCL_ADDR_CTRL_B 6'h09
`define RCL_ADDR_CTRL_C 6'h0A
`define RCL_ADDR_REF_LOCK_CFG 6'h0F

`define RCL_BIT_MEASURE_DONE 0
`define RCL_BIT_MEASURE_RESTART 0
`define RCL_BIT_MEASURE_ENABLE 1
`define RCL_MODE_LSB 4
`define RCL_MODE_MSB 6
`define RCL_MODE_REF_LOCK 3'h3
`define RCL_BIT_ACQUIRE_RESTART 6
`define RCL_BIT_REF_POWERDOWN 2
`define RCL_BIT_COMPARE_DATA 6
`define RCL_BAND_LSB 4
`define RCL_BAND_MSB 5
`define RCL_RATIO_LSB 0
`define RCL_RATIO_MSB 3

`define RCL_RST_CTRL_A 8'h00
`define RCL_RST_CTRL_B 8'h00
`define RCL_RST_CTRL_C 8'h04
`define RCL_RST_REF_LOCK_CFG 8'h00

`define RCL_WINDOW_LOG2 11
`define RCL_ACQ_PPM 24'h0000FA
`define RCL_TRK_PPM 24'h0003E8
`define RCL_PPM_SCALE 24'h0F4240

`endif

// ### src/rcl_rise_det.v
/*
 Rising edge detector for a sampled clock or tick level.
 Assumes the level is already synchronous to i_clock.
*/
`timescale 1ns/1ns
module rcl_rise_det (
   input wire i_clock,
   input wire i_rst,
   input wire i_level,
   output wire o_rise
);
   reg prev_q;

   always @(posedge i_clock) begin
      if (i_rst) begin
         prev_q <= 1'b0;
      end else begin
         prev_q <= i_level;
      end
   end

   assign o_rise = i_level & ~prev_q;
endmodule

// ### src/rcl_freq_cmp.v
/*
 Frequency error check of a measured count against a target count.
 Pure combinational; the caller samples the outputs at window end.
*/
`timescale 1ns/1ns
`include "rcl_regs.vh"
module rcl_freq_cmp (
   input wire [23:0] i_measured,
   input wire [23:0] i_target,
   output wire o_within_acq,
   output wire o_beyond_trk
);
   // ----------------------------------------------------------------
   // Error scaling
   // ----------------------------------------------------------------
   // Cross-multiplied so no divider is needed
   function [47:0] rcl_scale;
      input [23:0] value;
      input [23:0] factor;
      begin
         rcl_scale = {24'h000000, value} * {24'h000000, factor};
      end
   endfunction

   localparam [23:0] PPM_ACQ = `RCL_ACQ_PPM;
   localparam [23:0] PPM_TRK = `RCL_TRK_PPM;
   localparam [23:0] PPM_SCALE = `RCL_PPM_SCALE;

   wire [23:0] err = (i_measured > i_target) ? (i_measured - i_target) :
                     (i_target - i_measured);

   // RULE_20: acquisition window
   assign o_within_acq = rcl_scale(err, PPM_SCALE) <= rcl_scale(i_target, PPM_ACQ);
   // RULE_09: tracking threshold
   assign o_beyond_trk = rcl_scale(err, PPM_SCALE) > rcl_scale(i_target, PPM_TRK);
endmodule

// ### src/rcl_ref_clock_ctrl.v
/*
 Reference clock control: reference-assisted lock detector and fine
 data rate measurement, with the byte register file behind the
 serial control port.
 Assumes the serial slave presents one-cycle write strobes with byte
 address and data, and that reference, oscillator and data tick
 levels arrive already synchronous to i_clock. Oscillator and data
 ticks are the recovered rates divided by 2**OSC_DIV_LOG2.
*/
`timescale 1ns/1ns
`include "rcl_regs.vh"
module rcl_ref_clock_ctrl #(
   parameter OSC_DIV_LOG2 = 7
) (
   input wire i_clock,
   input wire i_rst,
   input wire i_reg_wr,
   input wire [5:0] i_reg_addr,
   input wire [7:0] i_reg_wdata,
   input wire [7:0] i_rate_readback_two,
   input wire i_reference_clock_in,
   input wire i_osc_tick,
   input wire i_data_tick,
   input wire i_recovery_lock_lost,
   output reg [7:0] o_reg_rdata,
   output reg o_lock_lost,
   output reg o_ref_buffer_on,
   output reg o_tracking,
   output reg o_measure_busy
);
   // ----------------------------------------------------------------
   // States
   // ----------------------------------------------------------------
   localparam [2:0] LK_OFF = 3'h1;
   localparam [2:0] LK_ACQ = 3'h2;
   localparam [2:0] LK_TRACK = 3'h4;
   localparam [1:0] MS_IDLE = 2'h1;
   localparam [1:0] MS_RUN = 2'h2;

   // ----------------------------------------------------------------
   // Helpers
   // ----------------------------------------------------------------
   // RULE_17: window of 2048 divided-reference periods
   function [14:0] rcl_window_last;
      input [1:0] band;
      reg [31:0] len;
      begin
         len = 32'h1 << (`RCL_WINDOW_LOG2 + band);
         rcl_window_last = len[14:0] - 15'h0001;
      end
   endfunction

   // RULE_05: expected oscillator ticks per window
   function [23:0] rcl_ref_target;
      input [3:0] ratio;
      reg [31:0] t;
      begin
         t = (32'h1 << (`RCL_WINDOW_LOG2 + ratio)) >> (OSC_DIV_LOG2 + 1);
         rcl_ref_target = t[23:0];
      end
   endfunction

   // ----------------------------------------------------------------
   // Register file
   // ----------------------------------------------------------------
   reg [7:0] ctrl_a_q;
   reg [7:0] ctrl_b_q;
   reg [7:0] ctrl_c_q;
   reg [7:0] ref_cfg_q;
   reg [23:0] result_q;
   reg measure_done_q;

   wire wr_a = i_reg_wr & (i_reg_addr == `RCL_ADDR_CTRL_A);
   wire wr_b = i_reg_wr & (i_reg_addr == `RCL_ADDR_CTRL_B);
   wire wr_c = i_reg_wr & (i_reg_addr == `RCL_ADDR_CTRL_C);
   wire wr_f = i_reg_wr & (i_reg_addr == `RCL_ADDR_REF_LOCK_CFG);

   // RULE_13: restart fires on the 1-to-0 write
   wire measure_restart = wr_a & ctrl_a_q[`RCL_BIT_MEASURE_RESTART] &
                          ~i_reg_wdata[`RCL_BIT_MEASURE_RESTART];
   wire acquire_restart = wr_b & ctrl_b_q[`RCL_BIT_ACQUIRE_RESTART] &
                          ~i_reg_wdata[`RCL_BIT_ACQUIRE_RESTART];

   always @(posedge i_clock) begin
      if (i_rst) begin
         ctrl_a_q <= `RCL_RST_CTRL_A;
         ctrl_b_q <= `RCL_RST_CTRL_B;
         ctrl_c_q <= `RCL_RST_CTRL_C;
         ref_cfg_q <= `RCL_RST_REF_LOCK_CFG;
      end else begin
         if (wr_a) begin
            ctrl_a_q <= i_reg_wdata;
         end
         if (wr_b) begin
            ctrl_b_q <= i_reg_wdata;
         end
         // RULE_02: power-down held until cleared by software
         if (wr_c) begin
            ctrl_c_q <= i_reg_wdata;
         end
         // RULE_06: band and ratio fields stored as written
         if (wr_f) begin
            ref_cfg_q <= i_reg_wdata;
         end
      end
   end

   wire ref_on = ~ctrl_c_q[`RCL_BIT_REF_POWERDOWN];
   wire [1:0] band = ref_cfg_q[`RCL_BAND_MSB:`RCL_BAND_LSB];
   // RULE_07: ratio code
   wire [3:0] ratio = ref_cfg_q[`RCL_RATIO_MSB:`RCL_RATIO_LSB];
   wire compare_data = ref_cfg_q[`RCL_BIT_COMPARE_DATA];
   // RULE_01: mode decode
   wire lock_mode = (ctrl_a_q[`RCL_MODE_MSB:`RCL_MODE_LSB] == `RCL_MODE_REF_LOCK) & ref_on;
   // RULE_03: measurement armed
   wire measure_enable = ctrl_a_q[`RCL_BIT_MEASURE_ENABLE] & ref_on;

   // ----------------------------------------------------------------
   // Edge detection
   // ----------------------------------------------------------------
   wire ref_rise_raw;
   wire osc_rise;
   wire data_rise;

   rcl_rise_det u_ref_rise (
      .i_clock(i_clock),
      .i_rst(i_rst),
      .i_level(i_reference_clock_in),
      .o_rise(ref_rise_raw)
   );
   rcl_rise_det u_osc_rise (
      .i_clock(i_clock),
      .i_rst(i_rst),
      .i_level(i_osc_tick),
      .o_rise(osc_rise)
   );
   rcl_rise_det u_data_rise (
      .i_clock(i_clock),
      .i_rst(i_rst),
      .i_level(i_data_tick),
      .o_rise(data_rise)
   );

   // A powered-down buffer delivers no reference edges
   wire ref_rise = ref_rise_raw & ref_on;

   // ----------------------------------------------------------------
   // Shared window and tick counters
   // ----------------------------------------------------------------
   // Software never runs lock and measurement together, so one window serves both
   reg [2:0] lk_state_q;
   reg [2:0] lk_state_d;
   reg [1:0] ms_state_q;
   reg [1:0] ms_state_d;
   reg [14:0] win_cnt_q;
   reg [23:0] osc_cnt_q;
   reg [23:0] data_cnt_q;

   wire lock_start = lock_mode & ((lk_state_q == LK_OFF) | acquire_restart);
   wire meas_start = measure_restart & measure_enable;
   wire win_restart = lock_start | meas_start;
   wire win_end = ref_rise & (win_cnt_q == rcl_window_last(band)) & ~win_restart;
   wire [23:0] osc_now = osc_cnt_q + {23'h000000, osc_rise};
   wire [23:0] data_now = data_cnt_q + {23'h000000, data_rise};

   always @(posedge i_clock) begin
      if (i_rst) begin
         win_cnt_q <= 15'h0000;
         osc_cnt_q <= 24'h000000;
         data_cnt_q <= 24'h000000;
      end else if (win_restart | win_end) begin
         win_cnt_q <= 15'h0000;
         osc_cnt_q <= 24'h000000;
         data_cnt_q <= 24'h000000;
      end else begin
         if (ref_rise) begin
            win_cnt_q <= win_cnt_q + 15'h0001;
         end
         osc_cnt_q <= osc_now;
         data_cnt_q <= data_now;
      end
   end

   // ----------------------------------------------------------------
   // Lock detector
   // ----------------------------------------------------------------
   wire [23:0] ref_target = rcl_ref_target(ratio);
   // RULE_10: tracking compares against data when selected
   wire [23:0] trk_target = compare_data ? data_now : ref_target;
   wire within_acq;
   wire beyond_trk;

   rcl_freq_cmp u_cmp_acq (
      .i_measured(osc_now),
      .i_target(ref_target),
      .o_within_acq(within_acq),
      .o_beyond_trk()
   );
   rcl_freq_cmp u_cmp_trk (
      .i_measured(osc_now),
      .i_target(trk_target),
      .o_within_acq(),
      .o_beyond_trk(beyond_trk)
   );

   always @* begin
      lk_state_d = lk_state_q;
      case (lk_state_q)
         LK_OFF: begin
            if (lock_mode) begin
               lk_state_d = LK_ACQ;
            end
         end
         LK_ACQ: begin
            // RULE_20: release once close to target
            if (win_end & within_acq) begin
               lk_state_d = LK_TRACK;
            end
         end
         LK_TRACK: begin
            // RULE_09: relock to the reference on large error
            if (win_end & beyond_trk) begin
               lk_state_d = LK_ACQ;
            end
         end
         default: begin
            lk_state_d = LK_OFF;
         end
      endcase
      if (!lock_mode) begin
         lk_state_d = LK_OFF;
      end else if (acquire_restart) begin
         lk_state_d = LK_ACQ;
      end
   end

   // ----------------------------------------------------------------
   // Measurement
   // ----------------------------------------------------------------
   always @* begin
      ms_state_d = ms_state_q;
      case (ms_state_q)
         MS_IDLE: begin
            if (meas_start) begin
               ms_state_d = MS_RUN;
            end
         end
         MS_RUN: begin
            if (win_end) begin
               ms_state_d = MS_IDLE;
            end
         end
         default: begin
            ms_state_d = MS_IDLE;
         end
      endcase
      // RULE_12: dropping the level abandons a run
      if (!measure_enable) begin
         ms_state_d = MS_IDLE;
      end else if (meas_start) begin
         ms_state_d = MS_RUN;
      end
   end

   always @(posedge i_clock) begin
      if (i_rst) begin
         lk_state_q <= LK_OFF;
         ms_state_q <= MS_IDLE;
         result_q <= 24'h000000;
         measure_done_q <= 1'b0;
      end else begin
         lk_state_q <= lk_state_d;
         ms_state_q <= ms_state_d;
         // RULE_13: restart clears the flag, overriding a completion
         if (meas_start) begin
            measure_done_q <= 1'b0;
         end else if ((ms_state_q == MS_RUN) & win_end & measure_enable) begin
            // RULE_21: whole result latched with the flag
            // RULE_11: data ticks counted over the reference window
            result_q <= data_now;
            // RULE_14: done once the window closes
            measure_done_q <= 1'b1;
         end
      end
   end

   // ----------------------------------------------------------------
   // Outputs and read data
   // ----------------------------------------------------------------
   reg [7:0] rdata_d;

   always @* begin
      case (i_reg_addr)
         // RULE_15: high byte first
         `RCL_ADDR_COUNT_HIGH: rdata_d = result_q[23:16];
         `RCL_ADDR_COUNT_MID: rdata_d = result_q[15:8];
         `RCL_ADDR_COUNT_LOW: rdata_d = result_q[7:0];
         `RCL_ADDR_RATE_READBACK: rdata_d = i_rate_readback_two;
         `RCL_ADDR_STATUS: rdata_d = {7'h00, measure_done_q};
         `RCL_ADDR_CTRL_A: rdata_d = ctrl_a_q;
         `RCL_ADDR_CTRL_B: rdata_d = ctrl_b_q;
         `RCL_ADDR_CTRL_C: rdata_d = ctrl_c_q;
         `RCL_ADDR_REF_LOCK_CFG: rdata_d = ref_cfg_q;
         default: rdata_d = 8'h00;
      endcase
   end

   always @(posedge i_clock) begin
      if (i_rst) begin
         o_reg_rdata <= 8'h00;
         o_lock_lost <= 1'b1;
         o_ref_buffer_on <= 1'b0;
         o_tracking <= 1'b0;
         o_measure_busy <= 1'b0;
      end else begin
         o_reg_rdata <= rdata_d;
         // Outside reference lock the rest of the receiver owns the flag
         o_lock_lost <= (lk_state_d == LK_OFF) ? i_recovery_lock_lost :
                        (lk_state_d != LK_TRACK);
         o_ref_buffer_on <= ref_on;
         o_tracking <= (lk_state_d == LK_TRACK);
         o_measure_busy <= (ms_state_d == MS_RUN);
      end
   end
endmodule

// ### bench/rcl_ctrl_asserts.sv
/*
 Concurrent checks on the ports of the reference clock control block.
 Assumes a bind onto rcl_ref_clock_ctrl and one clock domain.
*/
`timescale 1ns/1ns
module rcl_ctrl_asserts #(
   parameter OSC_DIV_LOG2 = 7
) (
   input wire i_clock,
   input wire i_rst,
   input wire i_reg_wr,
   input wire [5:0] i_reg_addr,
   input wire [7:0] i_reg_wdata,
   input wire [7:0] i_rate_readback_two,
   input wire i_reference_clock_in,
   input wire i_osc_tick,
   input wire i_data_tick,
   input wire i_recovery_lock_lost,
   input wire [7:0] o_reg_rdata,
   input wire o_lock_lost,
   input wire o_ref_buffer_on,
   input wire o_tracking,
   input wire o_measure_busy
);
   // -------------------------------
   // Shadow of the fields we rely on
   // -------------------------------
   reg [2:0] mode_q;
   reg [1:0] band_q;
   reg rst_bit_q;
   reg en_q;
   reg ref_q;
   reg stale_q;
   reg [15:0] rises_q;
   wire wr_a = i_reg_wr && (i_reg_addr == 6'h08);
   wire pulse = wr_a && rst_bit_q && !i_reg_wdata[0];
   wire [15:0] win = 16'h0800 << band_q;

   always @(posedge i_clock) begin
      if (i_rst) begin
         mode_q <= 3'h0;
         band_q <= 2'h0;
         rst_bit_q <= 1'b0;
         en_q <= 1'b0;
         ref_q <= 1'b0;
         stale_q <= 1'b1;
         rises_q <= 16'h0000;
      end else begin
         ref_q <= i_reference_clock_in;
         if (wr_a) begin
            mode_q <= i_reg_wdata[6:4];
            rst_bit_q <= i_reg_wdata[0];
            en_q <= i_reg_wdata[1];
         end
         if (i_reg_wr && (i_reg_addr == 6'h0F)) begin
            band_q <= i_reg_wdata[5:4];
         end
         // Any other write may abort or reshape the window
         stale_q <= pulse ? 1'b0 : (stale_q | i_reg_wr);
         if (pulse) begin
            rises_q <= 16'h0000;
         end else if (i_reference_clock_in && !ref_q) begin
            rises_q <= rises_q + 16'h0001;
         end
      end
   end

   default clocking @(posedge i_clock); endclocking
   default disable iff (i_rst);

   // -------------------------------
   // Properties
   // -------------------------------
   a_reset_state:
   assert property (disable iff (1'b0) i_rst |=> o_lock_lost && !o_ref_buffer_on
      && !o_tracking && !o_measure_busy && (o_reg_rdata == 8'h00))
      else $error("outputs not at reset state");
   a_buffer_ctrl:
   // Output flop lags the control register by one more cycle
   assert property (i_reg_wr && (i_reg_addr == 6'h0A) |-> ##2
      o_ref_buffer_on == !$past(i_reg_wdata[2], 2)) else $error("buffer enable wrong");
   a_mode_off:
   assert property ((mode_q != 3'h3) && !wr_a && !$past(i_rst) |=>
      !o_tracking && (o_lock_lost == $past(i_recovery_lock_lost)))
      else $error("lock logic active outside lock mode");
   a_restart_busy:
   assert property (pulse && en_q && o_ref_buffer_on |=> o_measure_busy)
      else $error("restart did not start measurement");
   a_enable_abort:
   assert property (wr_a && !i_reg_wdata[1] |-> ##[1:2] !o_measure_busy)
      else $error("measurement runs without enable");
   a_window_len:
   assert property ($fell(o_measure_busy) && !stale_q |->
      (rises_q + 16'h0002 >= win) && (rises_q <= win + 16'h0001))
      else $error("measurement window length wrong");
   a_status_run:
   assert property ($past(o_measure_busy) && ($past(i_reg_addr) == 6'h06)
      && !$past(i_rst) |-> o_reg_rdata == 8'h00) else $error("done read high while busy");
   a_track_clear:
   assert property ($rose(o_tracking) |-> $fell(o_lock_lost))
      else $error("tracking entered without clearing lock lost");
   a_relock_flag:
   assert property ($fell(o_tracking) && (mode_q == 3'h3) && o_ref_buffer_on |-> o_lock_lost)
      else $error("tracking left without lock lost");
   a_buffer_track:
   assert property (!o_ref_buffer_on && !$past(o_ref_buffer_on) |-> !o_tracking)
      else $error("tracking with buffer off");
endmodule

// ### bench/rcl_tone_model.sv
/*
 Free running square wave source standing in for the reference
 oscillator and the divided recovered rates.
 Assumes i_half is at least 1; a change takes effect at once.
*/
`timescale 1ns/1ns
module rcl_tone_model (
   input wire i_clock,
   input wire i_rst,
   input wire [7:0] i_half,
   output reg o_level
);
   reg [7:0] cnt_q;
   // sources whose rate ratio is measured
   always @(posedge i_clock) begin
      if (i_rst) begin
         cnt_q <= 8'h00;
         o_level <= 1'b0;
      end else if (cnt_q + 8'h01 >= i_half) begin
         cnt_q <= 8'h00;
         o_level <= ~o_level;
      end else begin
         cnt_q <= cnt_q + 8'h01;
      end
   end
endmodule

// ### bench/test_rcl_ref_clock_ctrl.sv
/*
 Self-checking bench of the reference clock control block.
 Assumes tick sources from rcl_tone_model and the checker bound below.
*/
`timescale 1ns/1ns
module test_rcl_ref_clock_ctrl;
   reg i_clock = 1'b0;
   reg i_rst = 1'b1;
   reg i_reg_wr = 1'b0;
   reg [5:0] i_reg_addr = 6'h00;
   reg [7:0] i_reg_wdata = 8'h00;
   reg [7:0] i_rate_readback_two = 8'h00;
   reg i_recovery_lock_lost = 1'b1;
   reg [7:0] ref_half = 8'h01;
   reg [7:0] osc_half = 8'h20;
   reg [7:0] dat_half = 8'h02;
   wire ref_clk, osc_tick, dat_tick, o_lock_lost, o_ref_buffer_on, o_tracking, o_measure_busy;
   wire [7:0] o_reg_rdata;
   integer fails = 0;
   integer compares = 0;
   integer i, n, dh, rt, exp_cnt;
   reg [7:0] rv;
   reg [23:0] cnt = 24'h000000;
   reg [23:0] prev;
   localparam [47:0] RA = 48'h08090A0F063F;
   localparam [47:0] RV = 48'h000004000000;
   localparam integer WIN = 4096;

   always #5 i_clock = ~i_clock;

   rcl_tone_model ref_src (.i_clock(i_clock), .i_rst(i_rst), .i_half(ref_half), .o_level(ref_clk));
   rcl_tone_model osc_src (.i_clock(i_clock), .i_rst(i_rst), .i_half(osc_half), .o_level(osc_tick));
   rcl_tone_model dat_src (.i_clock(i_clock), .i_rst(i_rst), .i_half(dat_half), .o_level(dat_tick));

   rcl_ref_clock_ctrl #(.OSC_DIV_LOG2(7)) uut (.i_clock(i_clock), .i_rst(i_rst),
      .i_reg_wr(i_reg_wr), .i_reg_addr(i_reg_addr), .i_reg_wdata(i_reg_wdata),
      .i_rate_readback_two(i_rate_readback_two), .i_reference_clock_in(ref_clk),
      .i_osc_tick(osc_tick), .i_data_tick(dat_tick), .i_recovery_lock_lost(i_recovery_lock_lost),
      .o_reg_rdata(o_reg_rdata), .o_lock_lost(o_lock_lost), .o_ref_buffer_on(o_ref_buffer_on),
      .o_tracking(o_tracking), .o_measure_busy(o_measure_busy));

   // -------------------------------
   // Shared tasks
   // -------------------------------
   task check(input [23:0] seen, input [23:0] exp);
      begin
         compares = compares + 1;
         if (seen !== exp) begin
            fails = fails + 1;
            $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
         end
      end
   endtask

   task tally_and_finish;
      begin
         if (fails == 0 && compares > 0) $display("== PASSED ==");
         else $display("== FAILED ==");
         $finish;
      end
   endtask

   task wr(input [5:0] a, input [7:0] d);
      begin
         @(posedge i_clock);
         i_reg_wr <= 1'b1;
         i_reg_addr <= a;
         i_reg_wdata <= d;
         @(posedge i_clock);
         i_reg_wr <= 1'b0;
      end
   endtask

   task rd(input [5:0] a);
      begin
         @(posedge i_clock);
         i_reg_addr <= a;
         repeat (2) @(posedge i_clock);
         #1 rv = o_reg_rdata;
      end
   endtask

   task read_count;
      begin
         rd(6'h00);
         cnt[23:16] = rv;
         rd(6'h01);
         cnt[15:8] = rv;
         rd(6'h02);
         cnt[7:0] = rv;
      end
   endtask

   // Bounded wait: 0 busy low, 1 tracking high, 2 lock lost high
   task wait_for(input integer sel, input integer lim);
      begin
         n = 0;
         while (n < lim && !((sel == 0 && o_measure_busy === 1'b0) ||
               (sel == 1 && o_tracking === 1'b1) || (sel == 2 && o_lock_lost === 1'b1))) begin
            @(posedge i_clock);
            #1 n = n + 1;
         end
         if (n >= lim) begin
            fails = fails + 1;
            tally_and_finish;
         end
      end
   endtask

   task measure(input integer band);
      begin
         prev = cnt;
         wr(6'h0F, band << 4);
         wr(6'h08, 8'h03);
         wr(6'h08, 8'h02);
         #1 check(o_measure_busy, 1'b1);
         rd(6'h06);
         check(rv, 8'h00);
         read_count;
         check(cnt, prev);
         wait_for(0, (WIN << band) * ref_half + 64);
         rd(6'h06);
         check(rv, 8'h01);
         read_count;
         exp_cnt = (WIN << band) * ref_half / (2 * dh);
         check((cnt + 1 >= exp_cnt) && (cnt <= exp_cnt + 1), 1'b1);
         check(o_lock_lost, 1'b0);
      end
   endtask

   // -------------------------------
   // Main sequence
   // -------------------------------
   initial begin
      rt = $urandom(2);
      repeat (16) @(posedge i_clock);
      i_rst <= 1'b0;
      i_rate_readback_two <= $urandom_range(0, 255);
      for (i = 0; i < 6; i = i + 1) begin
         rd(RA[8 * (5 - i) +: 6]);
         check(rv, RV[8 * (5 - i) +: 8]);
      end
      rd(6'h05);
      check(rv, i_rate_readback_two);
      i_recovery_lock_lost <= 1'b0;
      repeat (3) @(posedge i_clock);
      #1 check(o_lock_lost, 1'b0);
      for (i = 0; i < 11; i = i + 1) begin
         wr(6'h0F, ((i % 4) << 4) | i);
         rd(6'h0F);
         check(rv, ((i % 4) << 4) | i);
      end
      wr(6'h08, 8'h03);
      wr(6'h08, 8'h02);
      repeat (2) @(posedge i_clock);
      #1 check(o_measure_busy, 1'b0);
      wr(6'h0A, 8'h00);
      @(posedge i_clock);
      #1 check(o_ref_buffer_on, 1'b1);
      // Result bytes are read-only
      wr(6'h00, 8'hA5);
      for (i = 0; i < 2; i = i + 1) begin
         dh = $urandom_range(2, 5);
         dat_half <= dh;
         measure(i);
      end
      prev = cnt;
      wr(6'h08, 8'h03);
      wr(6'h08, 8'h02);
      repeat (100) @(posedge i_clock);
      wr(6'h08, 8'h00);
      repeat (2) @(posedge i_clock);
      #1 check(o_measure_busy, 1'b0);
      rd(6'h06);
      check(rv, 8'h00);
      read_count;
      check(cnt, prev);
      rt = $urandom_range(1, 6);
      osc_half <= 256 >> rt;
      wr(6'h0F, rt);
      wr(6'h08, 8'h30);
      repeat (2) @(posedge i_clock);
      #1 check(o_lock_lost, 1'b1);
      wait_for(1, 5 * WIN);
      check(o_lock_lost, 1'b0);
      osc_half <= (256 >> rt) + (128 >> rt);
      wait_for(2, 3 * WIN);
      check(o_tracking, 1'b0);
      osc_half <= 256 >> rt;
      dat_half <= (256 >> rt) + (128 >> rt);
      wr(6'h0F, 8'h40 | rt);
      // acquire restart after a field change
      wr(6'h09, 8'h40);
      wr(6'h09, 8'h00);
      wait_for(1, 5 * WIN);
      wait_for(2, 3 * WIN);
      check(o_lock_lost, 1'b1);
      dat_half <= 256 >> rt;
      wait_for(1, 5 * WIN);
      repeat (2 * WIN + 8) @(posedge i_clock);
      #1 check(o_tracking, 1'b1);
      wr(6'h08, 8'h00);
      repeat (2) @(posedge i_clock);
      #1 check(o_tracking, 1'b0);
      check(o_lock_lost, 1'b0);
      tally_and_finish;
   end
endmodule

bind rcl_ref_clock_ctrl rcl_ctrl_asserts #(.OSC_DIV_LOG2(OSC_DIV_LOG2)) chk (.i_clock,
   .i_rst, .i_reg_wr, .i_reg_addr, .i_reg_wdata, .i_rate_readback_two, .i_reference_clock_in,
   .i_osc_tick, .i_data_tick, .i_recovery_lock_lost, .o_reg_rdata, .o_lock_lost,
   .o_ref_buffer_on, .o_tracking, .o_measure_busy);
